// [rtl/dtc_pkg.sv]
// Constants, types and lookup for the termination selection block
package dtc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] REG_MODE_ONE_OFS = 8'h00;
  localparam logic [7:0] REG_MODE_TWO_OFS = 8'h04;
  localparam logic [7:0] REG_MODE_FIVE_OFS = 8'h08;
  localparam logic [7:0] REG_LATENCY_OFS = 8'h0C;
  localparam logic [7:0] REG_STATUS_OFS = 8'h10;

  // ==========================================================
  // Field positions
  localparam int NOM_LSB = 8;
  localparam int WR_LSB = 9;
  localparam int PARK_LSB = 6;
  localparam int RL_LSB = 0;
  localparam int WL_LSB = 8;
  localparam int PRE2_BIT = 16;
  localparam int BC4_BIT = 17;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_MODE_EN_BIT = 4;
  localparam int ST_SREF_BIT = 5;
  localparam int ST_RX_EN_BIT = 6;
  localparam int ST_OHMS_LSB = 8;

  // ==========================================================
  // Reset values and latency figures
  localparam logic [2:0] CODE_OFF = 3'h0;
  localparam logic [2:0] WR_CODE_MAX = 3'h3;
  localparam logic [5:0] RL_RST = 6'h0B;
  localparam logic [5:0] WL_RST = 6'h09;
  localparam logic [5:0] ADJ_PRE1 = 6'h02;
  localparam logic [5:0] ADJ_PRE2 = 6'h03;
  localparam logic [5:0] LAT_ZERO = 6'h00;
  localparam logic [5:0] LAT_ONE = 6'h01;
  localparam logic [3:0] HALF_BL8 = 4'h4;
  localparam logic [3:0] HALF_BC4 = 4'h2;
  localparam int HIST_W = 64;

  // ==========================================================
  // Resistance values in ohms
  localparam logic [7:0] OHM_NONE = 8'h00;
  localparam logic [7:0] OHM_240 = 8'hF0;
  localparam logic [7:0] OHM_120 = 8'h78;
  localparam logic [7:0] OHM_80 = 8'h50;
  localparam logic [7:0] OHM_60 = 8'h3C;
  localparam logic [7:0] OHM_48 = 8'h30;
  localparam logic [7:0] OHM_40 = 8'h28;
  localparam logic [7:0] OHM_34 = 8'h22;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    DTC_HIZ, DTC_RD_OFF, DTC_WR, DTC_NOM, DTC_PARK
  } dtc_state_t;

  typedef enum logic [1:0] {
    WIN_IDLE, WIN_WAIT, WIN_ACTIVE
  } dtc_win_state_t;

  typedef struct packed {
    logic [2:0] nom_code;
    logic [2:0] wr_code;
    logic [2:0] park_code;
    logic [5:0] read_latency;
    logic [5:0] write_latency;
    logic pre2;
    logic bc4;
  } dtc_cfg_t;

  // Strobe order: upper true, upper comp, lower true, lower comp
  typedef struct packed {
    dtc_state_t state;
    logic [15:0] dq_en;
    logic [3:0] strobe_en;
    logic [1:0] mask_en;
    logic [7:0] ohms;
  } dtc_term_t;

  // Code zero is off; each next code is the next smaller value
  function automatic logic [7:0] dtc_ohms(input logic [2:0] code,
                                          input logic is_wr);
    logic [7:0] r;
    case (code)
      3'h1: r = OHM_240;
      3'h2: r = OHM_120;
      3'h3: r = OHM_80;
      3'h4: r = OHM_60;
      3'h5: r = OHM_48;
      3'h6: r = OHM_40;
      3'h7: r = OHM_34;
      default: r = OHM_NONE;
    endcase
    // Write field stops at 80 ohms; higher codes act as off
    if (is_wr && code > WR_CODE_MAX) begin
      r = OHM_NONE;
    end
    return r;
  endfunction

endpackage

// [rtl/dtc_window.sv]
// Delayed timing window started by a command
`timescale 1ns/10ps
module dtc_window (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [5:0] delay,
  input wire logic [3:0] length,
  output logic active
);

  dtc_pkg::dtc_win_state_t st_q, st_d;
  logic [5:0] cnt_q, cnt_d;

  // ==========================================================
  // Next state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      dtc_pkg::WIN_WAIT: begin
        if (cnt_q == dtc_pkg::LAT_ONE) begin
          st_d = dtc_pkg::WIN_ACTIVE;
          cnt_d = {2'b00, length};
        end else begin
          cnt_d = cnt_q - dtc_pkg::LAT_ONE;
        end
      end
      dtc_pkg::WIN_ACTIVE: begin
        if (cnt_q == dtc_pkg::LAT_ONE) begin
          st_d = dtc_pkg::WIN_IDLE;
        end
        cnt_d = cnt_q - dtc_pkg::LAT_ONE;
      end
      default: begin
        st_d = dtc_pkg::WIN_IDLE;
      end
    endcase
    // A new command restarts the window; overlap is not merged
    // Registered output adds a cycle, so the wait is one shorter
    if (start) begin
      if (delay <= dtc_pkg::LAT_ONE) begin
        st_d = dtc_pkg::WIN_ACTIVE;
        cnt_d = {2'b00, length};
      end else begin
        st_d = dtc_pkg::WIN_WAIT;
        cnt_d = delay - dtc_pkg::LAT_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= dtc_pkg::WIN_IDLE;
      cnt_q <= dtc_pkg::LAT_ZERO;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign active = (st_q == dtc_pkg::WIN_ACTIVE);

endmodule

// [rtl/dtc_term_ctrl.sv]
// Termination selection for the data, strobe and mask inputs
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/10ps
module dtc_term_ctrl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic term_pin,
  input wire logic cmd_write,
  input wire logic cmd_read,
  input wire logic self_refresh,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output dtc_pkg::dtc_term_t term,
  output logic term_pin_rx_en
);

  dtc_pkg::dtc_cfg_t cfg_q, cfg_d;
  dtc_pkg::dtc_term_t term_q, term_d;
  logic [31:0] rdata_q, rdata_d;
  logic [dtc_pkg::HIST_W-1:0] hist_q, hist_d;
  logic rx_en_q, rx_en_d;

  logic nom_en, wr_en, park_en, mode_en;
  logic pin_gated, pin_dly;
  logic rd_act, wr_act;
  logic [5:0] adj, rd_dly, wr_dly;
  logic [3:0] win_len;

  // ==========================================================
  // Decoded settings
  assign nom_en = (cfg_q.nom_code != dtc_pkg::CODE_OFF);
  // Reserved write codes count as off
  assign wr_en = (cfg_q.wr_code != dtc_pkg::CODE_OFF) &&
                 (cfg_q.wr_code <= dtc_pkg::WR_CODE_MAX);
  assign park_en = (cfg_q.park_code != dtc_pkg::CODE_OFF);
  // Any non-zero code counts, reserved write codes too
  assign mode_en = nom_en || (cfg_q.wr_code != dtc_pkg::CODE_OFF) ||
                   park_en;
  assign adj = cfg_q.pre2 ? dtc_pkg::ADJ_PRE2 : dtc_pkg::ADJ_PRE1;
  // Latencies shorter than the adjustment start at once
  assign rd_dly = (cfg_q.read_latency > adj) ?
                  cfg_q.read_latency - adj : dtc_pkg::LAT_ZERO;
  assign wr_dly = (cfg_q.write_latency > adj) ?
                  cfg_q.write_latency - adj : dtc_pkg::LAT_ZERO;
  assign win_len = (cfg_q.bc4 ? dtc_pkg::HALF_BC4 : dtc_pkg::HALF_BL8) +
                   adj[3:0];

  // ==========================================================
  // Pin receiver and synchronous nominal latency
  assign pin_gated = term_pin && nom_en && !self_refresh;
  assign pin_dly = (wr_dly == dtc_pkg::LAT_ZERO) ? pin_gated :
                   hist_q[wr_dly - dtc_pkg::LAT_ONE];

  // ==========================================================
  // Read and write windows
  dtc_window u_rd_win (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(cmd_read && !self_refresh),
    .delay(rd_dly),
    .length(win_len),
    .active(rd_act)
  );

  dtc_window u_wr_win (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(cmd_write && !self_refresh),
    .delay(wr_dly),
    .length(win_len),
    .active(wr_act)
  );

  // ==========================================================
  // Register file
  always_comb begin
    cfg_d = cfg_q;
    rdata_d = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        dtc_pkg::REG_MODE_ONE_OFS: begin
          cfg_d.nom_code = reg_wdata[dtc_pkg::NOM_LSB +: 3];
        end
        dtc_pkg::REG_MODE_TWO_OFS: begin
          cfg_d.wr_code = reg_wdata[dtc_pkg::WR_LSB +: 3];
        end
        dtc_pkg::REG_MODE_FIVE_OFS: begin
          cfg_d.park_code = reg_wdata[dtc_pkg::PARK_LSB +: 3];
        end
        dtc_pkg::REG_LATENCY_OFS: begin
          cfg_d.read_latency = reg_wdata[dtc_pkg::RL_LSB +: 6];
          cfg_d.write_latency = reg_wdata[dtc_pkg::WL_LSB +: 6];
          cfg_d.pre2 = reg_wdata[dtc_pkg::PRE2_BIT];
          cfg_d.bc4 = reg_wdata[dtc_pkg::BC4_BIT];
        end
        default: begin
          cfg_d = cfg_q;
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        dtc_pkg::REG_MODE_ONE_OFS: begin
          rdata_d[dtc_pkg::NOM_LSB +: 3] = cfg_q.nom_code;
        end
        dtc_pkg::REG_MODE_TWO_OFS: begin
          rdata_d[dtc_pkg::WR_LSB +: 3] = cfg_q.wr_code;
        end
        dtc_pkg::REG_MODE_FIVE_OFS: begin
          rdata_d[dtc_pkg::PARK_LSB +: 3] = cfg_q.park_code;
        end
        dtc_pkg::REG_LATENCY_OFS: begin
          rdata_d[dtc_pkg::RL_LSB +: 6] = cfg_q.read_latency;
          rdata_d[dtc_pkg::WL_LSB +: 6] = cfg_q.write_latency;
          rdata_d[dtc_pkg::PRE2_BIT] = cfg_q.pre2;
          rdata_d[dtc_pkg::BC4_BIT] = cfg_q.bc4;
        end
        dtc_pkg::REG_STATUS_OFS: begin
          rdata_d[dtc_pkg::ST_STATE_LSB +: 3] = term_q.state;
          rdata_d[dtc_pkg::ST_MODE_EN_BIT] = mode_en;
          rdata_d[dtc_pkg::ST_SREF_BIT] = self_refresh;
          rdata_d[dtc_pkg::ST_RX_EN_BIT] = rx_en_q;
          rdata_d[dtc_pkg::ST_OHMS_LSB +: 8] = term_q.ohms;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_q <= '{nom_code: dtc_pkg::CODE_OFF, wr_code: dtc_pkg::CODE_OFF,
                 park_code: dtc_pkg::CODE_OFF,
                 read_latency: dtc_pkg::RL_RST,
                 write_latency: dtc_pkg::WL_RST,
                 pre2: 1'b0, bc4: 1'b0};
      rdata_q <= 32'h0000_0000;
    end else begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================
  // Termination selection
  always_comb begin
    term_d = '0;
    hist_d = {hist_q[dtc_pkg::HIST_W-2:0], pin_gated};
    rx_en_d = nom_en && !self_refresh;
    if (self_refresh) begin
      term_d.state = dtc_pkg::DTC_HIZ;
    end else if (rd_act) begin
      term_d.state = dtc_pkg::DTC_RD_OFF;
    end else if (wr_act && wr_en) begin
      term_d.state = dtc_pkg::DTC_WR;
    end else if (nom_en && pin_dly) begin
      term_d.state = dtc_pkg::DTC_NOM;
    end else if (park_en) begin
      term_d.state = dtc_pkg::DTC_PARK;
    end else begin
      term_d.state = dtc_pkg::DTC_HIZ;
    end
    case (term_d.state)
      dtc_pkg::DTC_WR: begin
        term_d.ohms = dtc_pkg::dtc_ohms(cfg_q.wr_code, 1'b1);
      end
      dtc_pkg::DTC_NOM: begin
        term_d.ohms = dtc_pkg::dtc_ohms(cfg_q.nom_code, 1'b0);
      end
      dtc_pkg::DTC_PARK: begin
        term_d.ohms = dtc_pkg::dtc_ohms(cfg_q.park_code, 1'b0);
      end
      default: begin
        term_d.ohms = dtc_pkg::OHM_NONE;
      end
    endcase
    // One switch state for every terminated line
    term_d.dq_en = {16{term_d.ohms != dtc_pkg::OHM_NONE}};
    term_d.strobe_en = {4{term_d.ohms != dtc_pkg::OHM_NONE}};
    term_d.mask_en = {2{term_d.ohms != dtc_pkg::OHM_NONE}};
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      term_q <= '0;
      hist_q <= '0;
      rx_en_q <= 1'b0;
    end else begin
      term_q <= term_d;
      hist_q <= hist_d;
      rx_en_q <= rx_en_d;
    end
  end

  assign term = term_q;
  assign term_pin_rx_en = rx_en_q;

  // ==========================================================
  // Checking helpers: age of the last read command
  logic [5:0] rd_age_q, rd_age_d, rd_cap_q, rd_cap_d;

  always_comb begin
    rd_age_d = rd_age_q;
    rd_cap_d = rd_cap_q;
    if (cmd_read && !self_refresh) begin
      rd_age_d = dtc_pkg::LAT_ZERO;
      rd_cap_d = (rd_dly > dtc_pkg::LAT_ONE) ? rd_dly - dtc_pkg::LAT_ONE :
                 dtc_pkg::LAT_ZERO;
    end else if (rd_age_q != 6'h3F) begin
      rd_age_d = rd_age_q + dtc_pkg::LAT_ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_age_q <= 6'h3F;
      rd_cap_q <= dtc_pkg::LAT_ZERO;
    end else begin
      rd_age_q <= rd_age_d;
      rd_cap_q <= rd_cap_d;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  all_lines_a: assert property (
    (term.dq_en == {16{term.strobe_en[0]}}) &&
    (term.strobe_en == {4{term.mask_en[0]}}) &&
    (term.mask_en == {2{term.ohms != dtc_pkg::OHM_NONE}}))
    else $error("terminated lines disagree");

  sref_hiz_a: assert property (
    self_refresh |=> (term.state == dtc_pkg::DTC_HIZ) && !term.dq_en[0])
    else $error("termination on during self refresh");

  pin_ignored_a: assert property (
    (cfg_q.nom_code == dtc_pkg::CODE_OFF || self_refresh)
    |=> term.state != dtc_pkg::DTC_NOM)
    else $error("pin used while it must be ignored");

  mode_off_a: assert property (
    (!mode_en && !rd_act) |=> term.state == dtc_pkg::DTC_HIZ)
    else $error("termination on with all fields zero");

  write_term_a: assert property (
    (wr_act && wr_en && !rd_act && !self_refresh)
    |=> (term.state == dtc_pkg::DTC_WR) &&
        (term.ohms == dtc_pkg::dtc_ohms($past(cfg_q.wr_code), 1'b1)))
    else $error("write window without write termination");

  nom_on_a: assert property (
    (nom_en && pin_dly && !rd_act && !(wr_act && wr_en) && !self_refresh)
    |=> term.state == dtc_pkg::DTC_NOM)
    else $error("nominal termination missing with pin high");

  park_a: assert property (
    (park_en && !pin_dly && !rd_act && !(wr_act && wr_en) &&
     !self_refresh) |=> term.state == dtc_pkg::DTC_PARK)
    else $error("park termination missing with pin low");

  read_start_a: assert property (
    $rose(rd_act) |-> rd_age_q == rd_cap_q)
    else $error("read disable started at wrong latency");

  read_first_a: assert property (
    (rd_act && !self_refresh) |=> term.state == dtc_pkg::DTC_RD_OFF &&
                                  term.ohms == dtc_pkg::OHM_NONE)
    else $error("read did not override termination");

  idle_hiz_a: assert property (
    (!park_en && !pin_dly && !rd_act && !(wr_act && wr_en))
    |=> term.state == dtc_pkg::DTC_HIZ)
    else $error("high impedance expected");

  rx_off_a: assert property (
    (cfg_q.nom_code == dtc_pkg::CODE_OFF) |=> !term_pin_rx_en)
    else $error("pin receiver powered with nominal off");

  nom_value_a: assert property (
    (term.state == dtc_pkg::DTC_NOM) |->
    term.ohms == dtc_pkg::dtc_ohms($past(cfg_q.nom_code), 1'b0))
    else $error("nominal resistance wrong");

  localparam int LAT_CHK = 7;

  nom_latency_a: assert property (
    (nom_en && !park_en && !wr_act && !rd_act && !self_refresh &&
     wr_dly == LAT_CHK && $stable(cfg_q) && pin_gated &&
     $past(pin_gated) == 1'b0) ##LAT_CHK
    (!rd_act && !wr_act && nom_en && !self_refresh)
    |=> term.state == dtc_pkg::DTC_NOM)
    else $error("nominal did not follow pin latency");

  read_cov_c: cover property ($rose(rd_act) ##[1:16] $fell(rd_act));
  write_cov_c: cover property (term.state == dtc_pkg::DTC_WR);
  nom_cov_c: cover property (term.state == dtc_pkg::DTC_NOM);
  park_cov_c: cover property (term.state == dtc_pkg::DTC_PARK ##1
                              term.state == dtc_pkg::DTC_NOM);

endmodule

// [bench/dtc_ctl_model.sv]
// Controller model: drives commands, the termination pin and self refresh
`timescale 1ns/10ps
module dtc_ctl_model (
  input wire logic sys_clk,
  output logic term_pin,
  output logic cmd_write,
  output logic cmd_read,
  output logic self_refresh
);
  initial begin
    term_pin = 1'b0;
    cmd_write = 1'b0;
    cmd_read = 1'b0;
    self_refresh = 1'b0;
  end

  // ==========================================================
  // Pulses drop by themselves; only clear when high to avoid a race
  always @(posedge sys_clk) begin
    if (cmd_read || cmd_write) begin
      cmd_read <= 1'b0;
      cmd_write <= 1'b0;
    end
  end

  // ==========================================================
  // Steering tasks; callers leave a gap between pulses
  task automatic issue(input logic rd, input logic wr);
    @(posedge sys_clk);
    cmd_read <= rd;
    cmd_write <= wr;
  endtask

  task automatic set_pin(input logic p);
    @(posedge sys_clk);
    term_pin <= p;
  endtask

  task automatic set_sref(input logic s);
    @(posedge sys_clk);
    self_refresh <= s;
  endtask
endmodule

// [bench/dtc_term_ctrl_test.sv]
// Self-checking bench for the termination selection block
`timescale 1ns/10ps
module dtc_term_ctrl_test;
  logic sys_clk;
  logic rst_n;
  logic term_pin;
  logic cmd_write;
  logic cmd_read;
  logic self_refresh;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  dtc_pkg::dtc_term_t term;
  logic term_pin_rx_en;
  int n_mismatch;
  int checks_done;
  int seed;
  int rl;
  int wl;
  int xx;
  int half;
  logic [2:0] nom;
  logic [2:0] wrc;
  logic [2:0] park;
  logic pre2;
  logic bc4;
  logic pin;

  dtc_term_ctrl dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .term_pin(term_pin),
    .cmd_write(cmd_write), .cmd_read(cmd_read),
    .self_refresh(self_refresh), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .term(term), .term_pin_rx_en(term_pin_rx_en)
  );

  dtc_ctl_model ctl (
    .sys_clk(sys_clk), .term_pin(term_pin), .cmd_write(cmd_write),
    .cmd_read(cmd_read), .self_refresh(self_refresh)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    wrap_up();
  end

  // ==========================================================
  // Expectations
  function automatic logic [7:0] ohm_of(input logic [2:0] c, input logic w);
    logic [63:0] tbl;
    tbl = 64'h2228_303c_5078_f000; // Byte per code, in ohms
    if (w && c > 3'h3) begin
      return 8'h00;
    end
    return tbl[c*8 +: 8];
  endfunction

  function automatic logic [63:0] exp_term(input dtc_pkg::dtc_state_t s,
                                           input logic [7:0] o);
    dtc_pkg::dtc_term_t t;
    logic en;
    en = (o != 8'h00);
    t.state = s;
    t.dq_en = {16{en}};
    t.strobe_en = {4{en}};
    t.mask_en = {2{en}};
    t.ohms = o;
    return 64'(t);
  endfunction

  function automatic logic [63:0] base_term(input logic p);
    if (nom != 3'h0 && p) begin
      return exp_term(dtc_pkg::DTC_NOM, ohm_of(nom, 1'b0));
    end
    if (park != 3'h0) begin
      return exp_term(dtc_pkg::DTC_PARK, ohm_of(park, 1'b0));
    end
    return exp_term(dtc_pkg::DTC_HIZ, 8'h00);
  endfunction

  // ==========================================================
  // Register bus
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check(64'(reg_rdata), 64'(e));
    tick();
    check(64'(reg_rdata), 64'h0);
  endtask

  // ==========================================================
  // Scenarios
  task automatic run_cmd(input logic rd, input logic wr);
    int dr;
    int dw;
    int len;
    logic [63:0] e;
    dr = rl - xx;
    dw = wl - xx;
    len = half + xx;
    ctl.issue(rd, wr);
    for (int i = 1; i <= (dr > dw ? dr : dw) + len + 2; i++) begin
      tick();
      e = base_term(pin);
      if (wr && ohm_of(wrc, 1'b1) != 8'h00 && i > dw && i <= dw + len) begin
        e = exp_term(dtc_pkg::DTC_WR, ohm_of(wrc, 1'b1));
      end
      if (rd && i > dr && i <= dr + len) begin
        e = exp_term(dtc_pkg::DTC_RD_OFF, 8'h00);
      end
      check(64'(term), e);
    end
  endtask

  task automatic pin_step();
    pin = !pin;
    ctl.set_pin(pin);
    for (int i = 1; i <= wl - xx + 2; i++) begin
      tick();
      check(64'(term), base_term(i > wl - xx ? pin : !pin));
    end
  endtask

  task automatic sref_run();
    ctl.set_sref(1'b1);
    ctl.issue(1'b1, 1'b1);
    for (int i = 1; i <= rl + 8; i++) begin
      tick();
      check(64'(term), exp_term(dtc_pkg::DTC_HIZ, 8'h00));
    end
    ctl.set_sref(1'b0);
    repeat (wl + 4) tick();
    check(64'(term), base_term(pin));
  endtask

  task automatic set_cfg(input int i);
    logic [63:0] e;
    // Corner cases: reserved write code alone, then every field off
    nom = (i < 8) ? 3'(i) : (i < 10) ? 3'h0 : 3'($random(seed));
    park = (i < 8) ? 3'(7 - i) : (i < 10) ? 3'h0 : 3'($random(seed));
    wrc = (i < 8) ? 3'(i) : (i == 8) ? 3'h4 :
          (i == 9) ? 3'h0 : 3'($random(seed));
    pre2 = 1'($random(seed));
    bc4 = 1'($random(seed));
    pin = 1'($random(seed));
    rl = 5 + int'($unsigned($random(seed)) % 12);
    wl = 5 + int'($unsigned($random(seed)) % 12);
    xx = pre2 ? 3 : 2;
    half = bc4 ? 2 : 4;
    wr_reg(dtc_pkg::REG_MODE_ONE_OFS, 32'(nom) << 8);
    wr_reg(dtc_pkg::REG_MODE_TWO_OFS, 32'(wrc) << 9);
    wr_reg(dtc_pkg::REG_MODE_FIVE_OFS, 32'(park) << 6);
    wr_reg(dtc_pkg::REG_LATENCY_OFS,
           {14'h0, bc4, pre2, 2'h0, 6'(wl), 2'h0, 6'(rl)});
    wr_reg(dtc_pkg::REG_STATUS_OFS, 32'hffff_ffff);
    ctl.set_pin(pin);
    repeat (wl + 4) tick();
    e = base_term(pin);
    check(64'(term), e);
    check(64'(term_pin_rx_en), 64'(nom != 3'h0));
    rd_reg(dtc_pkg::REG_STATUS_OFS, {16'h0, e[7:0], 1'b0, nom != 3'h0,
           1'b0, (nom | wrc | park) != 3'h0, 1'b0, e[32:30]});
  endtask

  initial begin
    seed = 32'hd2af_f2d6;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    tick();
    check(64'(term), 64'h0);
    rd_reg(dtc_pkg::REG_LATENCY_OFS, 32'h0000_090b);
    rd_reg(8'h14, 32'h0);
    for (int i = 0; i < 16; i++) begin
      set_cfg(i);
      run_cmd(1'b1, 1'b0);
      run_cmd(1'b0, 1'b1);
      run_cmd(1'b1, 1'b1);
      pin_step();
      run_cmd(1'b0, 1'b1);
      if (i % 3 == 0) begin
        sref_run();
      end
      $display("iteration %0d finished", i);
    end
    wrap_up();
  end
endmodule
